//--- hw/dual_timer_pkg.sv
// Purpose: Shared constants and types for the dual timer control and flag block
// Assumes: 16-bit byte address bus, 8-bit data
// Notes:   Interrupt status and mask registers sit at 16'hff3c and 16'hff3d, above the timer registers
`default_nettype none
package dual_timer_pkg;

    localparam logic [15:0] ADDR_EVENT_FLAGS   = 16'hff28;
    localparam logic [15:0] ADDR_TIMER0_CTRL   = 16'hff30;
    localparam logic [15:0] ADDR_TIMER1_CTRL   = 16'hff31;
    localparam logic [15:0] ADDR_RELOAD0_LOW   = 16'hff32;
    localparam logic [15:0] ADDR_IRQ_STATUS    = 16'hff3c;
    localparam logic [15:0] ADDR_IRQ_MASK      = 16'hff3d;

    localparam int CTRL_CASCADE_BIT = 7;
    localparam int CTRL_OUT_EN_BIT  = 3;
    localparam int CTRL_RUN_BIT     = 2;
    localparam int CTRL_LOAD_BIT    = 1;
    localparam int CTRL_SOURCE_BIT  = 0;

    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] RELOAD_RESET  = 8'hff;
    localparam logic [7:0] MASK_RESET    = 8'h00;

    // Event order matches flag bits 7 down to 0
    typedef struct packed {
        logic byte_timer_underflow;
        logic timer1_compare;
        logic timer1_underflow;
        logic timer0_compare;
        logic timer0_underflow;
        logic serial_tx_done;
        logic serial_rx_done;
        logic serial_rx_error;
    } event_type;

    typedef struct packed {
        logic run;
        logic output_enable;
        logic source_select;
        logic load;
    } timer_ctrl_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

endpackage
`default_nettype wire

//--- hw/sticky_flag_bank.sv
// Purpose: Bank of sticky event flags with one clear pulse per bit
// Assumes: Events and clears are synchronous to clk
// Notes:   A set in the clearing cycle wins
`timescale 1ns/10ps
`default_nettype none
module sticky_flag_bank
    import dual_timer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] set_in,
    input  wire logic [7:0] clear_in,
    output var  logic [7:0] flags_q
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    flags_q[i] <= FLAGS_RESET[i];
                end else if (set_in[i]) begin
                    flags_q[i] <= 1'h1;
                end else if (clear_in[i]) begin
                    flags_q[i] <= 1'h0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- hw/timer_ctrl_reg.sv
// Purpose: One timer control register with run, output, source and load bits
// Assumes: Write strobe already decoded for this register
// Notes:   The load bit is a one-cycle pulse and always reads 0
`timescale 1ns/10ps
`default_nettype none
module timer_ctrl_reg
    import dual_timer_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  wire logic           wr_en,
    input  wire logic [7:0]     wdata,
    output var  timer_ctrl_type ctrl_q,
    output var  logic [7:0]     read_value
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q.run           <= CTRL_RESET[CTRL_RUN_BIT];
            ctrl_q.output_enable <= CTRL_RESET[CTRL_OUT_EN_BIT];
            ctrl_q.source_select <= CTRL_RESET[CTRL_SOURCE_BIT];
        end else if (wr_en) begin
            ctrl_q.run           <= wdata[CTRL_RUN_BIT];
            ctrl_q.output_enable <= wdata[CTRL_OUT_EN_BIT];
            ctrl_q.source_select <= wdata[CTRL_SOURCE_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q.load <= CTRL_RESET[CTRL_LOAD_BIT];
        end else begin
            ctrl_q.load <= wr_en & wdata[CTRL_LOAD_BIT];
        end
    end

    always_comb begin
        read_value                  = 8'h00;
        read_value[CTRL_OUT_EN_BIT] = ctrl_q.output_enable;
        read_value[CTRL_RUN_BIT]    = ctrl_q.run;
        read_value[CTRL_SOURCE_BIT] = ctrl_q.source_select;
    end
endmodule
`default_nettype wire

//--- hw/dual_timer_control_flags.sv
// Purpose: Control and flag registers of a pair of 16-bit programmable timers
// Assumes: Event inputs are one-cycle pulses from logic on clk
// Notes:   Read data appear the cycle after the read strobe
//
// Notes on behaviour
// - Eight event flags set by timer and serial events, clear on writing 1
// - Timer0 control bit 7 selects cascaded 16-bit mode; bits 6-4 read 0
// - Control bit 3 enables that timer's clock output pin, reset 0
// - Control bit 2 runs the counter when 1, stops when 0, reset 0
// - Control bit 0 picks external clock when 1, internal when 0
// - Timer0 reload low byte is read/write and resets to all ones
`timescale 1ns/10ps
`default_nettype none
module dual_timer_control_flags
    import dual_timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [7:0]  rdata_q,
    input  wire event_type   events,
    output var  logic        cascade_select_q,
    output var  logic        timer0_run_q,
    output var  logic        timer1_run_q,
    output var  logic        timer0_output_enable_q,
    output var  logic        timer1_output_enable_q,
    output var  logic        timer0_source_select_q,
    output var  logic        timer1_source_select_q,
    output var  logic        timer0_load_q,
    output var  logic        timer1_load_q,
    output var  logic [7:0]  timer0_reload_low_q,
    output var  logic [7:0]  event_flags_q,
    output var  logic        irq_q
);
    bus_req_type    req;
    timer_ctrl_type ctrl0;
    timer_ctrl_type ctrl1;
    logic [7:0]     ctrl0_read;
    logic [7:0]     ctrl1_read;
    logic [7:0]     flags;
    logic [7:0]     irq_status;
    logic [7:0]     irq_mask_q;
    logic [7:0]     flag_clear;
    logic [7:0]     status_clear;
    logic [7:0]     rdata_d;
    logic           wr_flags;
    logic           wr_ctrl0;
    logic           wr_ctrl1;
    logic           wr_reload;
    logic           wr_mask;
    logic           rd_status;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    assign wr_flags  = req.wr && (req.addr == ADDR_EVENT_FLAGS);
    assign wr_ctrl0  = req.wr && (req.addr == ADDR_TIMER0_CTRL);
    assign wr_ctrl1  = req.wr && (req.addr == ADDR_TIMER1_CTRL);
    assign wr_reload = req.wr && (req.addr == ADDR_RELOAD0_LOW);
    assign wr_mask   = req.wr && (req.addr == ADDR_IRQ_MASK);
    assign rd_status = req.rd && (req.addr == ADDR_IRQ_STATUS);

    // Event flags: writing 1 clears, writing 0 leaves the bit alone
    assign flag_clear = wr_flags ? req.wdata : 8'h00;

    sticky_flag_bank u_event_flags (
        .clk      (clk),
        .arst_n   (arst_n),
        .set_in   (events),
        .clear_in (flag_clear),
        .flags_q  (flags)
    );

    // Interrupt status mirrors events but clears on read
    assign status_clear = rd_status ? 8'hff : 8'h00;

    sticky_flag_bank u_irq_status (
        .clk      (clk),
        .arst_n   (arst_n),
        .set_in   (events),
        .clear_in (status_clear),
        .flags_q  (irq_status)
    );

    timer_ctrl_reg u_ctrl0 (
        .clk        (clk),
        .arst_n     (arst_n),
        .wr_en      (wr_ctrl0),
        .wdata      (req.wdata),
        .ctrl_q     (ctrl0),
        .read_value (ctrl0_read)
    );

    timer_ctrl_reg u_ctrl1 (
        .clk        (clk),
        .arst_n     (arst_n),
        .wr_en      (wr_ctrl1),
        .wdata      (req.wdata),
        .ctrl_q     (ctrl1),
        .read_value (ctrl1_read)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cascade_select_q <= CTRL_RESET[CTRL_CASCADE_BIT];
        end else if (wr_ctrl0) begin
            cascade_select_q <= req.wdata[CTRL_CASCADE_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer0_reload_low_q <= RELOAD_RESET;
        end else if (wr_reload) begin
            timer0_reload_low_q <= req.wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= req.wdata;
        end
    end

    // Output copies keep every top output straight from a flip-flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer0_run_q <= CTRL_RESET[CTRL_RUN_BIT];
        end else begin
            timer0_run_q <= ctrl0.run;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer1_run_q <= CTRL_RESET[CTRL_RUN_BIT];
        end else begin
            timer1_run_q <= ctrl1.run;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer0_output_enable_q <= CTRL_RESET[CTRL_OUT_EN_BIT];
        end else begin
            timer0_output_enable_q <= ctrl0.output_enable;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer1_output_enable_q <= CTRL_RESET[CTRL_OUT_EN_BIT];
        end else begin
            timer1_output_enable_q <= ctrl1.output_enable;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer0_source_select_q <= CTRL_RESET[CTRL_SOURCE_BIT];
        end else begin
            timer0_source_select_q <= ctrl0.source_select;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer1_source_select_q <= CTRL_RESET[CTRL_SOURCE_BIT];
        end else begin
            timer1_source_select_q <= ctrl1.source_select;
        end
    end

    // Load copies stay one-cycle pulses, one edge after the write edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer0_load_q <= CTRL_RESET[CTRL_LOAD_BIT];
        end else begin
            timer0_load_q <= ctrl0.load;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer1_load_q <= CTRL_RESET[CTRL_LOAD_BIT];
        end else begin
            timer1_load_q <= ctrl1.load;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            event_flags_q <= FLAGS_RESET;
        end else begin
            event_flags_q <= flags;
        end
    end

    // Interrupt from the stored status so it clears with the read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'h0;
        end else begin
            irq_q <= |(irq_status & irq_mask_q);
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        unique case (req.addr)
            ADDR_EVENT_FLAGS: rdata_d = flags;
            ADDR_TIMER0_CTRL: rdata_d = {cascade_select_q, 3'h0, ctrl0_read[3:0]};
            ADDR_TIMER1_CTRL: rdata_d = ctrl1_read;
            ADDR_RELOAD0_LOW: rdata_d = timer0_reload_low_q;
            ADDR_IRQ_STATUS:  rdata_d = irq_status;
            ADDR_IRQ_MASK:    rdata_d = irq_mask_q;
            default:          rdata_d = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end
endmodule
`default_nettype wire

//--- verif/dual_timer_control_flags_chk.sv
// Purpose: Assertion checker for the dual timer control and flag block
// Assumes: One clock domain, read data one cycle after the strobe
// Notes:   Bound to the top module
`timescale 1ns/10ps
`default_nettype none
module dual_timer_chk
    import dual_timer_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata_q,
    input wire event_type   events,
    input wire logic        cascade_select_q,
    input wire logic        timer0_run_q,
    input wire logic        timer1_output_enable_q,
    input wire logic        timer1_source_select_q,
    input wire logic        timer1_load_q,
    input wire logic [7:0]  timer0_reload_low_q,
    input wire logic [7:0]  event_flags_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_FLAG_SET: assert property (|events |-> ##2 (event_flags_q & $past(events, 2)) == $past(events, 2))
        else $error("event flag not set");
    AST_FLAG_HOLD: assert property ((~event_flags_q & $past(event_flags_q)) != 8'h00
        |-> $past(wr && addr == ADDR_EVENT_FLAGS, 2)) else $error("flag cleared without a write");
    AST_CASCADE: assert property (wr && addr == ADDR_TIMER0_CTRL |=> cascade_select_q == $past(wdata[7]))
        else $error("mode select wrong");
    AST_OUT_EN1: assert property (wr && addr == ADDR_TIMER1_CTRL |-> ##2 timer1_output_enable_q == $past(wdata[3], 2))
        else $error("output enable wrong");
    AST_RUN0: assert property (wr && addr == ADDR_TIMER0_CTRL |-> ##2 timer0_run_q == $past(wdata[2], 2))
        else $error("run bit wrong");
    AST_SRC1: assert property (wr && addr == ADDR_TIMER1_CTRL |-> ##2 timer1_source_select_q == $past(wdata[0], 2))
        else $error("source select wrong");
    AST_RELOAD: assert property (wr && addr == ADDR_RELOAD0_LOW |=> timer0_reload_low_q == $past(wdata))
        else $error("reload byte wrong");
    AST_LOAD1: assert property (timer1_load_q == $past(wr && addr == ADDR_TIMER1_CTRL && wdata[1], 2))
        else $error("load pulse wrong");
    AST_CTRL0_READ: assert property (rd && addr == ADDR_TIMER0_CTRL |=> rdata_q[6:4] == 3'h0 && !rdata_q[1])
        else $error("unused control bits not zero");
endmodule
bind dual_timer_control_flags dual_timer_chk u_chk (.*);
`default_nettype wire

//--- verif/tb_dual_timer_control_flags.sv
// Purpose: Self-checking bench for the dual timer control and flag block
// Assumes: Bus master drives by non-blocking assignment after the edge
// Notes:   Register values come from an LFSR; a model tracks all registers
`timescale 1ns/10ps
`default_nettype none
module tb_dual_timer_control_flags
    import dual_timer_pkg::*;
;
    logic        clk = 1'h0, arst_n = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [15:0] addr = 16'h0000, seed = 16'h6f15;
    logic [7:0]  wdata = 8'h00, rdata_q, reload_q, flags_q;
    logic [7:0]  m_flags = 8'h00, m_stat = 8'h00, m_mask = 8'h00, m_c0 = 8'h00, m_c1 = 8'h00, m_rl = 8'hff;
    event_type   events = 8'h00;
    logic        casc, run0, run1, oe0, oe1, src0, src1, ld0, ld1, irq_q;
    int          err_count = 0, num_checks = 0;

    dual_timer_control_flags DUT (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .events(events), .cascade_select_q(casc), .timer0_run_q(run0), .timer1_run_q(run1),
        .timer0_output_enable_q(oe0), .timer1_output_enable_q(oe1), .timer0_source_select_q(src0),
        .timer1_source_select_q(src1), .timer0_load_q(ld0), .timer1_load_q(ld1),
        .timer0_reload_low_q(reload_q), .event_flags_q(flags_q), .irq_q(irq_q));

    always #5 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic irq_chk();
        check({7'h00, irq_q}, {7'h00, |(m_stat & m_mask)});
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        case (a)
            ADDR_EVENT_FLAGS: m_flags &= ~d;
            ADDR_TIMER0_CTRL: m_c0 = d & 8'h8d;
            ADDR_TIMER1_CTRL: m_c1 = d & 8'h0d;
            ADDR_RELOAD0_LOW: m_rl = d;
            ADDR_IRQ_MASK: m_mask = d;
            default: ;
        endcase
        @(posedge clk);
        #1;
        check({casc, oe0, run0, src0, oe1, run1, src1, ld0},
              {m_c0[7], m_c0[3:2], m_c0[0], m_c1[3:2], m_c1[0], a == ADDR_TIMER0_CTRL && d[1]});
        check({7'h00, ld1}, {7'h00, a == ADDR_TIMER1_CTRL && d[1]});
        check(reload_q, m_rl);
    endtask

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        check(rdata_q, e);
    endtask

    // Pulse events, optionally with a flag clear in the same cycle
    task automatic fire(input logic [7:0] e, input logic [7:0] clr);
        @(posedge clk);
        events <= e;
        addr <= ADDR_EVENT_FLAGS;
        wdata <= clr;
        wr <= |clr;
        @(posedge clk);
        events <= 8'h00;
        wr <= 1'h0;
        m_flags = (m_flags & ~clr) | e;
        m_stat |= e;
        @(posedge clk);
        #1;
        check(flags_q, m_flags);
        irq_chk();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        rd_reg(ADDR_EVENT_FLAGS, 8'h00);
        rd_reg(ADDR_TIMER0_CTRL, 8'h00);
        rd_reg(ADDR_TIMER1_CTRL, 8'h00);
        rd_reg(ADDR_RELOAD0_LOW, 8'hff);
        wr_reg(ADDR_TIMER0_CTRL, 8'hff);
        wr_reg(ADDR_TIMER1_CTRL, 8'hff);
        rd_reg(ADDR_TIMER0_CTRL, 8'h8d);
        rd_reg(ADDR_TIMER1_CTRL, 8'h0d);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            wr_reg(ADDR_TIMER0_CTRL, seed[7:0]);
            wr_reg(ADDR_TIMER1_CTRL, seed[15:8]);
            wr_reg(ADDR_RELOAD0_LOW, seed[11:4]);
            rd_reg(ADDR_TIMER0_CTRL, m_c0);
            rd_reg(ADDR_TIMER1_CTRL, m_c1);
            rd_reg(ADDR_RELOAD0_LOW, m_rl);
        end
        wr_reg(16'hff29, 8'hff);
        rd_reg(16'hff29, 8'h00);
        for (int i = 0; i < 8; i++) fire(8'h01 << i, 8'h00);
        wr_reg(ADDR_EVENT_FLAGS, 8'h00);
        wr_reg(ADDR_EVENT_FLAGS, 8'h0f);
        rd_reg(ADDR_EVENT_FLAGS, m_flags);
        fire(8'h01, 8'h01);
        wr_reg(ADDR_IRQ_MASK, 8'h10);
        irq_chk();
        rd_reg(ADDR_IRQ_STATUS, m_stat);
        m_stat = 8'h00;
        @(posedge clk);
        #1;
        irq_chk();
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr_reg(ADDR_IRQ_MASK, seed[15:8]);
            rd_reg(ADDR_IRQ_MASK, m_mask);
            fire(seed[7:0], seed[11:4]);
            rd_reg(ADDR_EVENT_FLAGS, m_flags);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
